// [design/apk_buffer.sv]
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module apk_buffer (
   // Clock and reset.
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave.
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Data flow controller channels.
   input  wire logic        dfc_wr_valid,
   input  wire logic [7:0]  dfc_wr_data,
   output logic             dfc_wr_ready,
   input  wire logic        dfc_rd_en,
   output logic             dfc_rd_avail,
   output logic      [7:0]  dfc_rd_data,
   output logic             dfc_rd_valid,
   // Audio processor side.
   input  wire logic        proc_wr_valid,
   input  wire logic [7:0]  proc_wr_data,
   output logic             proc_wr_ready,
   input  wire logic        proc_rd_en,
   output logic             proc_rd_avail,
   output logic      [7:0]  proc_rd_data,
   output logic             proc_rd_valid,
   output logic             proc_enable,
   output logic             code_load,
   output logic      [15:0] code_ptr,
   output logic             proc_irq
);
   import apk_pkg::*;

   // ---------------------------------------------------------------------
   // State
   // ---------------------------------------------------------------------
   typedef struct packed {
      apk_ctl_t    ctl;
      logic        req_en;
      logic        rdy_en;
      logic [15:0] code_ptr;
      apk_phase_t  ph;
      logic [31:0] hrdata;
      logic        hreadyout;
      logic        irq;
      logic        dfc_wr_ready;
      logic        dfc_rd_avail;
      logic [7:0]  dfc_rd_data;
      logic        dfc_rd_valid;
      logic        proc_wr_ready;
      logic        proc_rd_avail;
      logic [7:0]  proc_rd_data;
      logic        proc_rd_valid;
   } apk_state_t;

   localparam apk_state_t APK_STATE_RST = '{ctl: APK_CTL_RST, req_en: 1'b0,
      rdy_en: 1'b0, code_ptr: APK_CODE_RST, ph: '0, hrdata: 32'h00000000,
      hreadyout: 1'b1, irq: 1'b0, dfc_wr_ready: 1'b0, dfc_rd_avail: 1'b0,
      dfc_rd_data: 8'h00, dfc_rd_valid: 1'b0, proc_wr_ready: 1'b0,
      proc_rd_avail: 1'b0, proc_rd_data: 8'h00, proc_rd_valid: 1'b0};

   apk_state_t s;
   apk_state_t next_s;
   logic [7:0] mem [APK_MEM_BYTES];
   apk_ring_t  b0;
   apk_ring_t  b1;
   logic       split;
   logic       hw_en;
   logic       hr_en;
   logic       take;
   logic       cpu_push;
   logic       cpu_pop;
   logic       hw_push;
   logic       hr_pop;
   logic       pw_push;
   logic       pr_pop;
   logic       hr_empty;
   logic [9:0] hr_raddr;
   logic [9:0] pw_waddr;
   logic [7:0] hr_byte;
   logic [7:0] hw_byte;
   logic       flag_req;
   logic       flag_rdy;

   // ---------------------------------------------------------------------
   // Path steering
   // ---------------------------------------------------------------------
   // Split mode fixes ring 0 as host-to-processor and ring 1 as the return
   // path; a single buffer runs in the direction that stream_read_dir picks.
   assign split    = s.ctl.buffer_split_select;
   assign hw_en    = split | ~s.ctl.stream_read_dir;
   assign hr_en    = split | s.ctl.stream_read_dir;
   assign hr_empty = split ? b1.empty : b0.empty;
   assign hr_raddr = split ? b1.raddr : b0.raddr;
   assign pw_waddr = split ? b1.waddr : b0.waddr;
   assign hr_byte  = mem[hr_raddr];

   // Bus accesses to the data port move one byte each.
   assign take     = hsel & hready & (htrans == APK_HTRANS_NONSEQ)
                     & (hsize == APK_HSIZE_WORD);
   assign cpu_push = s.ph.valid & s.ph.write & (s.ph.ofs == APK_OFS_DATA)
                     & ~s.ctl.port_owner_select & hw_en & ~b0.full;
   assign cpu_pop  = take & ~hwrite & (haddr[7:0] == APK_OFS_DATA)
                     & ~s.ctl.port_owner_select & hr_en & ~hr_empty;

   // Owner select hands the host side to the CPU or to the controller.
   assign hw_push  = s.ctl.port_owner_select
                     ? (dfc_wr_valid & s.dfc_wr_ready) : cpu_push;
   assign hr_pop   = s.ctl.port_owner_select
                     ? (dfc_rd_en & s.dfc_rd_avail) : cpu_pop;
   assign hw_byte  = s.ctl.port_owner_select ? dfc_wr_data : hwdata[7:0];
   assign pw_push  = proc_wr_valid & s.proc_wr_ready;
   assign pr_pop   = proc_rd_en & s.proc_rd_avail;

   // Flags visible to software, each tied to its active direction.
   assign flag_req = hw_en & b0.req;
   assign flag_rdy = split ? b1.rdy : (s.ctl.stream_read_dir & b0.rdy);

   // ---------------------------------------------------------------------
   // Rings
   // ---------------------------------------------------------------------
   apk_ring #(.BANK(1'b0)) u_ring0 (
      .hclk    (hclk),
      .hresetn (hresetn),
      .split   (split),
      .push    (hw_push | (pw_push & ~split)),
      .pop     ((hr_pop & ~split) | pr_pop),
      .clr_r   (s.ctl.read_ptr_clear),
      .clr_w   (s.ctl.write_ptr_clear),
      .stat    (b0)
   );

   apk_ring #(.BANK(1'b1)) u_ring1 (
      .hclk    (hclk),
      .hresetn (hresetn),
      .split   (split),
      .push    (pw_push & split),
      .pop     (hr_pop & split),
      .clr_r   (s.ctl.read_ptr_clear),
      .clr_w   (s.ctl.write_ptr_clear),
      .stat    (b1)
   );

   // Byte store; the two writers never aim at the same ring.
   always_ff @(posedge hclk) begin
      if (hw_push) begin
         mem[b0.waddr] <= hw_byte;
      end
      if (pw_push) begin
         mem[pw_waddr] <= proc_wr_data;
      end
   end

   // ---------------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------------
   always_comb begin
      next_s = s;
      next_s.ctl.read_ptr_clear  = 1'b0;
      next_s.ctl.write_ptr_clear = 1'b0;
      next_s.hrdata    = 32'h00000000;
      next_s.hreadyout = 1'b1;
      next_s.ph.valid  = take;
      next_s.ph.write  = hwrite;
      next_s.ph.ofs    = haddr[7:0];
      // Read data is fetched in the address phase and shown in the data phase.
      if (take && !hwrite) begin
         case (haddr[7:0])
            APK_OFS_CTRL: begin
               next_s.hrdata = 32'(s.ctl);
            end
            APK_OFS_DATA: begin
               next_s.hrdata = 32'(cpu_pop ? hr_byte : 8'h00);
            end
            APK_OFS_FLAGS: begin
               next_s.hrdata = 32'({b1.empty, b1.full, b0.empty, b0.full,
                                    flag_rdy, flag_req});
            end
            APK_OFS_IEN: begin
               next_s.hrdata = 32'({s.rdy_en, s.req_en});
            end
            APK_OFS_CODE: begin
               next_s.hrdata = 32'(s.code_ptr);
            end
            default: begin
               next_s.hrdata = 32'h00000000;
            end
         endcase
      end
      // Code bytes advance the code pointer while loading is selected.
      if (hw_push && s.ctl.code_load_select) begin
         next_s.code_ptr = s.code_ptr + APK_CODE_ONE;
      end
      // Writes act in the data phase.
      if (s.ph.valid && s.ph.write) begin
         case (s.ph.ofs)
            APK_OFS_CTRL: begin
               next_s.ctl = apk_ctl_t'(hwdata[7:0]);
               if (s.ctl.processor_enable
                   && !next_s.ctl.processor_enable) begin
                  next_s.code_ptr = APK_CODE_RST;
               end
            end
            APK_OFS_IEN: begin
               next_s.req_en = hwdata[APK_IEN_REQ];
               next_s.rdy_en = hwdata[APK_IEN_RDY];
            end
            default: begin
               next_s.req_en = s.req_en;
            end
         endcase
      end
      // Interrupt request from enabled flags under the global enable.
      next_s.irq = next_s.ctl.global_audio_irq_enable
                   & ((flag_req & next_s.req_en)
                      | (flag_rdy & next_s.rdy_en));
      // Handshake outputs follow the next ring flags so they never lie.
      next_s.dfc_wr_ready  = next_s.ctl.port_owner_select
                             & (next_s.ctl.buffer_split_select
                                | ~next_s.ctl.stream_read_dir)
                             & ~b0.full_n;
      next_s.dfc_rd_avail  = next_s.ctl.port_owner_select
                             & (next_s.ctl.buffer_split_select
                                | next_s.ctl.stream_read_dir)
                             & ~(split ? b1.empty_n : b0.empty_n);
      next_s.proc_wr_ready = (next_s.ctl.buffer_split_select
                              | next_s.ctl.stream_read_dir)
                             & ~(split ? b1.full_n : b0.full_n);
      next_s.proc_rd_avail = (next_s.ctl.buffer_split_select
                              | ~next_s.ctl.stream_read_dir)
                             & ~b0.empty_n;
      next_s.dfc_rd_valid  = hr_pop & s.ctl.port_owner_select;
      next_s.dfc_rd_data   = next_s.dfc_rd_valid ? hr_byte : s.dfc_rd_data;
      next_s.proc_rd_valid = pr_pop;
      next_s.proc_rd_data  = pr_pop ? mem[b0.raddr] : s.proc_rd_data;
   end

   // State register.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= APK_STATE_RST;
      end else begin
         s <= next_s;
      end
   end

   // ---------------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------------
   assign hrdata        = s.hrdata;
   assign hreadyout     = s.hreadyout;
   assign hresp         = APK_HRESP_OKAY; // Constant OKAY response.
   assign dfc_wr_ready  = s.dfc_wr_ready;
   assign dfc_rd_avail  = s.dfc_rd_avail;
   assign dfc_rd_data   = s.dfc_rd_data;
   assign dfc_rd_valid  = s.dfc_rd_valid;
   assign proc_wr_ready = s.proc_wr_ready;
   assign proc_rd_avail = s.proc_rd_avail;
   assign proc_rd_data  = s.proc_rd_data;
   assign proc_rd_valid = s.proc_rd_valid;
   assign proc_enable   = s.ctl.processor_enable;
   assign code_load     = s.ctl.code_load_select;
   assign code_ptr      = s.code_ptr;
   assign proc_irq      = s.irq;

endmodule : apk_buffer
`default_nettype wire

// [design/apk_pkg.sv]
package apk_pkg;

   // ---------------------------------------------------------------------
   // Store geometry
   // ---------------------------------------------------------------------
   localparam int unsigned APK_MEM_BYTES = 1024;
   localparam int          APK_AW        = 10;
   localparam int          APK_PW        = 11;
   localparam logic [10:0] APK_PKT_SINGLE = 11'h200;
   localparam logic [10:0] APK_PKT_SPLIT  = 11'h100;
   localparam logic [10:0] APK_BUF_SINGLE = 11'h400;
   localparam logic [10:0] APK_BUF_SPLIT  = 11'h200;

   // ---------------------------------------------------------------------
   // Register map and fields
   // ---------------------------------------------------------------------
   localparam logic [7:0]  APK_OFS_CTRL   = 8'h00;
   localparam logic [7:0]  APK_OFS_DATA   = 8'h04;
   localparam logic [7:0]  APK_OFS_FLAGS  = 8'h08;
   localparam logic [7:0]  APK_OFS_IEN    = 8'h0C;
   localparam logic [7:0]  APK_OFS_CODE   = 8'h10;
   localparam int          APK_IEN_REQ    = 0;
   localparam int          APK_IEN_RDY    = 1;
   localparam logic [15:0] APK_CODE_RST   = 16'h0000;
   localparam logic [15:0] APK_CODE_ONE   = 16'h0001;

   // ---------------------------------------------------------------------
   // AHB-Lite encodings
   // ---------------------------------------------------------------------
   localparam logic [1:0]  APK_HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0]  APK_HSIZE_WORD    = 3'h2;
   localparam logic        APK_HRESP_OKAY    = 1'b0;

   // Control register, bit 0 is port_owner_select.
   typedef struct packed {
      logic global_audio_irq_enable;
      logic code_load_select;
      logic processor_enable;
      logic stream_read_dir;
      logic write_ptr_clear;
      logic read_ptr_clear;
      logic buffer_split_select;
      logic port_owner_select;
   } apk_ctl_t;

   localparam apk_ctl_t APK_CTL_RST = 8'h00;

   // Registered pointer state of one ring.
   typedef struct packed {
      logic [10:0] wptr;
      logic [10:0] rptr;
      logic        full;
      logic        empty;
      logic        req;
      logic        rdy;
   } apk_ring_st_t;

   localparam apk_ring_st_t APK_RING_RST = '{wptr: 11'h000, rptr: 11'h000,
      full: 1'b0, empty: 1'b1, req: 1'b1, rdy: 1'b0};

   // Status seen by the owner of a ring.
   typedef struct packed {
      logic       full;
      logic       empty;
      logic       full_n;
      logic       empty_n;
      logic       req;
      logic       rdy;
      logic [9:0] waddr;
      logic [9:0] raddr;
   } apk_ring_t;

   // Captured AHB address phase.
   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] ofs;
   } apk_phase_t;

endpackage : apk_pkg

// [design/apk_ring.sv]
`timescale 1ns/1ps
`default_nettype none
module apk_ring #(
   parameter logic BANK = 1'b0
) (
   // Clock and reset.
   input  wire logic          hclk,
   input  wire logic          hresetn,
   // Control.
   input  wire logic          split,
   input  wire logic          push,
   input  wire logic          pop,
   input  wire logic          clr_r,
   input  wire logic          clr_w,
   // Status.
   output apk_pkg::apk_ring_t stat
);
   import apk_pkg::*;

   apk_ring_st_t st;
   apk_ring_st_t next_st;
   logic [10:0]  diff;
   logic [10:0]  cnt;
   logic [10:0]  pkt;
   logic [10:0]  size;

   // Pointer moves, distance and packet flags.
   always_comb begin
      next_st = st;
      pkt     = split ? APK_PKT_SPLIT : APK_PKT_SINGLE;
      size    = split ? APK_BUF_SPLIT : APK_BUF_SINGLE;
      if (push) begin
         next_st.wptr = st.wptr + 11'h001;
      end
      if (pop) begin
         next_st.rptr = st.rptr + 11'h001;
      end
      if (clr_w) begin
         next_st.wptr = '0;
      end
      if (clr_r) begin
         next_st.rptr = '0;
      end
      diff = next_st.wptr - next_st.rptr;
      cnt  = split ? {1'b0, diff[9:0]} : diff;
      next_st.full  = (cnt == size);
      next_st.empty = (cnt == 11'h000);
      if (cnt <= pkt) begin
         next_st.req = 1'b1;
      end else if (next_st.full) begin
         next_st.req = 1'b0;
      end
      if (cnt >= pkt) begin
         next_st.rdy = 1'b1;
      end else if (next_st.empty) begin
         next_st.rdy = 1'b0;
      end
   end

   // State register.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= APK_RING_RST;
      end else begin
         st <= next_st;
      end
   end

   // Split mode places this ring in its own half of the store.
   always_comb begin
      stat.full    = st.full;
      stat.empty   = st.empty;
      stat.full_n  = next_st.full;
      stat.empty_n = next_st.empty;
      stat.req     = st.req;
      stat.rdy     = st.rdy;
      stat.waddr   = split ? {BANK, st.wptr[8:0]} : st.wptr[9:0];
      stat.raddr   = split ? {BANK, st.rptr[8:0]} : st.rptr[9:0];
   end

endmodule : apk_ring
`default_nettype wire

// [testbench/apk_buffer_properties.sv]
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------
// Port checker for the audio packet buffer
// ---------------------------------------------------------------------
module apk_buffer_properties (
   // Clock and reset.
   input wire logic        hclk,
   input wire logic        hresetn,
   // Register bus.
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // Streams and processor.
   input wire logic        dfc_wr_ready,
   input wire logic        dfc_rd_en,
   input wire logic        dfc_rd_avail,
   input wire logic        dfc_rd_valid,
   input wire logic        proc_rd_en,
   input wire logic        proc_rd_avail,
   input wire logic        proc_rd_valid,
   input wire logic        proc_enable,
   input wire logic [15:0] code_ptr,
   input wire logic        proc_irq
);
   import apk_pkg::*;
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   apk_phase_t ph;
   logic [7:0] ctl;
   logic [1:0] ien;
   // Shadows the address phase and the control and enable writes.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph  <= '0;
         ctl <= 8'h00;
         ien <= 2'h0;
      end else begin
         ph.valid <= hsel && hready && htrans == APK_HTRANS_NONSEQ
                     && hsize == APK_HSIZE_WORD;
         ph.write <= hwrite;
         ph.ofs   <= haddr[7:0];
         if (ph.valid && ph.write && ph.ofs == APK_OFS_CTRL) begin
            ctl <= hwdata[7:0] & 8'hF3;
         end
         if (ph.valid && ph.write && ph.ofs == APK_OFS_IEN) begin
            ien <= hwdata[1:0];
         end
      end
   end
   a_bus_okay: assert property (hreadyout && hresp == APK_HRESP_OKAY)
      else $error("bus answer not ready or not okay");
   a_ctl_selfclr: assert property (ph.valid && !ph.write
      && ph.ofs == APK_OFS_CTRL |-> hrdata[3:2] == 2'h0)
      else $error("pointer clear bits read back set");
   a_owner_port: assert property (ph.valid && !ph.write && ctl[0]
      && ph.ofs == APK_OFS_DATA |-> hrdata == 32'h0)
      else $error("data port answered while controller owns it");
   a_owner_dfc: assert property (!ctl[0] && !$past(ctl[0])
      |-> !dfc_wr_ready && !dfc_rd_avail)
      else $error("controller channel open while cpu owns buffer");
   a_irq_global: assert property (!ctl[7] |-> !proc_irq)
      else $error("interrupt without global enable");
   a_irq_enable: assert property (ien == 2'h0 |-> !proc_irq)
      else $error("interrupt with both flag enables clear");
   a_dfc_pulse: assert property (dfc_rd_en && dfc_rd_avail
      |=> dfc_rd_valid)
      else $error("controller pop without valid pulse");
   a_proc_pulse: assert property (!(proc_rd_en && proc_rd_avail)
      |=> !proc_rd_valid)
      else $error("processor valid without pop");
   a_code_zero: assert property ($fell(proc_enable)
      |-> ##[0:1] code_ptr == APK_CODE_RST)
      else $error("code pointer kept after disable");
   a_code_hold: assert property (!ctl[6] |=> $stable(code_ptr)
      || code_ptr == APK_CODE_RST)
      else $error("code pointer moved without load select");
endmodule : apk_buffer_properties
bind apk_buffer apk_buffer_properties i_props (
   .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
   .hready, .hrdata, .hreadyout, .hresp, .dfc_wr_ready, .dfc_rd_en,
   .dfc_rd_avail, .dfc_rd_valid, .proc_rd_en, .proc_rd_avail,
   .proc_rd_valid, .proc_enable, .code_ptr, .proc_irq
);
`default_nettype wire

// [testbench/apk_dfc_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------
// Data flow controller model, with random stalls between bytes
// ---------------------------------------------------------------------
module apk_dfc_model (
   // Clock.
   input  wire logic       hclk,
   // Channel into the buffer.
   output var logic        dfc_wr_valid,
   output var logic  [7:0] dfc_wr_data,
   input  wire logic       dfc_wr_ready,
   // Channel out of the buffer.
   output var logic        dfc_rd_en,
   input  wire logic       dfc_rd_avail,
   input  wire logic [7:0] dfc_rd_data,
   input  wire logic       dfc_rd_valid
);
   int unsigned stall = 0;
   logic [7:0]  rxq[$];
   initial begin
      dfc_wr_valid = 1'b0;
      dfc_wr_data  = 8'hA5;
      dfc_rd_en    = 1'b0;
   end
   // Collects every byte that the buffer hands out.
   always @(posedge hclk) begin
      if (dfc_rd_valid === 1'b1) begin
         rxq.push_back(dfc_rd_data);
      end
   end
   // Offers one byte and holds it until the buffer takes it.
   task automatic send(input logic [7:0] b);
      repeat ($urandom_range(stall)) @(posedge hclk);
      @(posedge hclk);
      dfc_wr_valid <= 1'b1;
      dfc_wr_data  <= b;
      do @(posedge hclk); while (dfc_wr_ready !== 1'b1);
      dfc_wr_valid <= 1'b0;
      dfc_wr_data  <= ~b;  // A released line never keeps the byte.
   endtask : send
   // Holds the pop request until the buffer grants it.
   task automatic fetch();
      repeat ($urandom_range(stall)) @(posedge hclk);
      @(posedge hclk);
      dfc_rd_en <= 1'b1;
      do @(posedge hclk); while (dfc_rd_avail !== 1'b1);
      dfc_rd_en <= 1'b0;
   endtask : fetch
endmodule : apk_dfc_model
`default_nettype wire

// [testbench/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check(32'(g), 32'(e))
// ---------------------------------------------------------------------
// Self-checking bench for the audio packet buffer
// ---------------------------------------------------------------------
module tb;
   import apk_pkg::*;
   logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rv;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = APK_HSIZE_WORD;
   logic hreadyout, hresp, dfc_wr_valid, dfc_wr_ready, dfc_rd_en;
   logic dfc_rd_avail, dfc_rd_valid, proc_wr_ready, proc_rd_avail;
   logic proc_wr_valid = 1'b0, proc_rd_en = 1'b0, proc_rd_valid;
   logic proc_enable, code_load, proc_irq;
   logic [7:0] dfc_wr_data, dfc_rd_data, proc_rd_data;
   logic [7:0] proc_wr_data = 8'h00;
   logic [15:0] code_ptr;
   logic [7:0] q0[$], q1[$], prx[$];
   int err_total = 0, total_checks = 0;
   apk_buffer i_dut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans,
      .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
      .hresp, .dfc_wr_valid, .dfc_wr_data, .dfc_wr_ready, .dfc_rd_en,
      .dfc_rd_avail, .dfc_rd_data, .dfc_rd_valid, .proc_wr_valid,
      .proc_wr_data, .proc_wr_ready, .proc_rd_en, .proc_rd_avail,
      .proc_rd_data, .proc_rd_valid, .proc_enable, .code_load, .code_ptr,
      .proc_irq);
   apk_dfc_model i_dfc (.hclk, .dfc_wr_valid, .dfc_wr_data, .dfc_wr_ready,
      .dfc_rd_en, .dfc_rd_avail, .dfc_rd_data, .dfc_rd_valid);
   always #2 hclk = ~hclk;
   // Collects bytes handed to the processor.
   always @(posedge hclk) begin
      if (proc_rd_valid === 1'b1) begin
         prx.push_back(proc_rd_data);
      end
   end
   task automatic check(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask : check
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : conclude
   // One single-word transfer; read data is taken at the data phase end.
   task automatic ahb(input logic w, input logic [7:0] a,
                      input logic [31:0] wd);
      @(posedge hclk);
      htrans <= APK_HTRANS_NONSEQ;
      haddr  <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rv = hrdata;
   endtask : ahb
   task automatic pput(input logic [7:0] b);
      @(posedge hclk);
      proc_wr_valid <= 1'b1;
      proc_wr_data  <= b;
      do @(posedge hclk); while (proc_wr_ready !== 1'b1);
      proc_wr_valid <= 1'b0;
      proc_wr_data  <= ~b;
   endtask : pput
   task automatic pget();
      repeat ($urandom_range(2)) @(posedge hclk);
      @(posedge hclk);
      proc_rd_en <= 1'b1;
      do @(posedge hclk); while (proc_rd_avail !== 1'b1);
      proc_rd_en <= 1'b0;
   endtask : pget
   // Cuts a hung run short.
   initial begin
      #240000;
      err_total++;
      conclude();
   end
   initial begin
      logic [7:0] b;
      void'($urandom(62056));
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b0, APK_OFS_FLAGS, 32'h0);
      `CHK(rv, 32'h29);
      ahb(1'b1, 8'h14, 32'hFF);
      ahb(1'b0, 8'h14, 32'h0);
      `CHK(rv, 32'h0);
      // Single buffer toward the processor: fill past full, then drain.
      for (int i = 0; i < 1025; i++) begin
         b = 8'($urandom);
         if (i < 1024) q0.push_back(b);
         ahb(1'b1, APK_OFS_DATA, {24'h0, b});
         if (i == 511 || i == 1024) begin
            ahb(1'b0, APK_OFS_FLAGS, 32'h0);
            `CHK(rv, (i == 511) ? 32'h21 : 32'h24);
         end
      end
      for (int i = 0; i < 1024; i++) begin
         pget();
         if (i == 511) begin
            ahb(1'b0, APK_OFS_FLAGS, 32'h0);
            `CHK(rv, 32'h21);
         end
      end
      repeat (2) @(posedge hclk);
      `CHK(prx.size(), 1024);
      for (int i = 0; i < 1024; i++) `CHK(prx[i], q0[i]);
      q0.delete();
      prx.delete();
      // Interrupt gated by the flag enables and the global enable.
      ahb(1'b1, APK_OFS_IEN, 32'h1);
      repeat (3) @(posedge hclk);
      `CHK(proc_irq, 1'b0);
      ahb(1'b1, APK_OFS_CTRL, 32'h80);
      repeat (3) @(posedge hclk);
      `CHK(proc_irq, 1'b1);
      ahb(1'b1, APK_OFS_IEN, 32'h2);
      repeat (3) @(posedge hclk);
      `CHK(proc_irq, 1'b0);
      // Split buffers owned by the controller; flag enables stay clear.
      ahb(1'b1, APK_OFS_IEN, 32'h0);
      ahb(1'b1, APK_OFS_CTRL, 32'h03);
      i_dfc.stall = 2;
      for (int i = 0; i < 256; i++) begin
         b = 8'($urandom);
         q0.push_back(b);
         i_dfc.send(b);
      end
      for (int i = 0; i < 256; i++) begin
         b = 8'($urandom);
         q1.push_back(b);
         pput(b);
      end
      ahb(1'b0, APK_OFS_FLAGS, 32'h0);
      `CHK(rv, 32'h03);
      ahb(1'b0, APK_OFS_DATA, 32'h0);
      `CHK(rv, 32'h0);
      fork
         for (int k = 0; k < 256; k++) pget();
         for (int k = 0; k < 256; k++) i_dfc.fetch();
      join
      repeat (2) @(posedge hclk);
      for (int i = 0; i < 256; i++) `CHK(prx[i], q0[i]);
      for (int i = 0; i < 256; i++) `CHK(i_dfc.rxq[i], q1[i]);
      ahb(1'b0, APK_OFS_FLAGS, 32'h0);
      `CHK(rv, 32'h29);
      // Pointer clears empty a ring and read back as zero.
      ahb(1'b1, APK_OFS_CTRL, 32'h02);
      repeat (3) ahb(1'b1, APK_OFS_DATA, 32'($urandom));
      ahb(1'b1, APK_OFS_CTRL, 32'h0E);
      ahb(1'b0, APK_OFS_CTRL, 32'h0);
      `CHK(rv, 32'h02);
      ahb(1'b0, APK_OFS_FLAGS, 32'h0);
      `CHK(rv, 32'h29);
      // Single buffer from the processor, read through the data port.
      ahb(1'b1, APK_OFS_CTRL, 32'h10);
      for (int i = 0; i < 4; i++) begin
         b = 8'($urandom);
         pput(b);
         ahb(1'b0, APK_OFS_DATA, 32'h0);
         `CHK(rv, b);
      end
      // Code pointer counts loaded bytes and drops on disable.
      ahb(1'b1, APK_OFS_CTRL, 32'h60);
      repeat (5) ahb(1'b1, APK_OFS_DATA, 32'($urandom));
      ahb(1'b1, APK_OFS_CTRL, 32'h20);
      ahb(1'b0, APK_OFS_CODE, 32'h0);
      `CHK(rv, 32'h5);
      ahb(1'b1, APK_OFS_CTRL, 32'h00);
      repeat (2) @(posedge hclk);
      `CHK(code_ptr, APK_CODE_RST);
      conclude();
   end
endmodule : tb
`default_nettype wire
